// ===== match_entry_defines.vh
/*
 * Constants for the frame match entry classifier: register offsets,
 * entry word field positions, frame type codes and frame constants.
 * Assumes a 32-bit classic Wishbone slave with byte addressing.
 */
`ifndef MATCH_ENTRY_DEFINES_VH
`define MATCH_ENTRY_DEFINES_VH

// Register byte offsets
`define SEL_OFS 8'h00
`define LIM_OFS 8'h04
`define STAT_OFS 8'h08
`define SHUT_OFS 8'h0c
`define W0_OFS 8'h10
`define W1_OFS 8'h14
`define W2_OFS 8'h18
`define W3_OFS 8'h1c
`define W4_OFS 8'h20
`define CNT_OFS 8'h24

// Status fields
`define ST_BUSY 0
`define ST_HIT 1
`define ST_IDX_LSB 16

// Entry word 0 fields
`define W0_PORT_SPEC 0
`define W0_PORT_LSB 1
`define PORT_W 5
`define W0_POL_SPEC 6
`define W0_TYPE_LSB 7
`define TYPE_W 3
`define W0_PERMIT 10
`define W0_RATE_LSB 11
`define RATE_W 5
`define W0_REDIR_EN 16
`define W0_REDIR_LSB 17
`define W0_LOG 22
`define W0_SHUT 23
`define W0_SRC_SPEC 24
`define W0_DST_LSB 25
`define DST_W 3
`define W0_VID_SPEC 28
`define W0_PRIO_SPEC 29

// Entry word 2 and 4 fields
`define W2_DST_HI_LSB 16
`define W4_POL_VAL_LSB 0
`define W4_POL_MASK_LSB 8
`define W4_VID_LSB 16
`define W4_PRIO_LSB 28

// Frame type selector codes
`define FT_ANY 3'h0
`define FT_ETH 3'h1
`define FT_ARP 3'h2
`define FT_IP4 3'h3
`define FT_IP6 3'h4

// Destination address modes
`define DM_ANY 3'h0
`define DM_MULTICAST_ONLY 3'h1
`define DM_BROADCAST_ONLY 3'h2
`define DM_UNICAST_ONLY 3'h3
`define DM_SPEC 3'h4

// Frame constants
`define ETYPE_MIN 16'h0600
`define ETYPE_ARP 16'h0806
`define ETYPE_RARP 16'h8035
`define ETYPE_IP4 16'h0800
`define ETYPE_IP6 16'h86dd
`define BCAST_ADDR 48'hffffffffffff
`define GROUP_BIT 40
`define MAX_REPORT_LEN 14'h5ee

`endif

// ===== frame_access_list_classifier.v
/*
 * Frame access list classifier: holds a list of match entries written
 * over classic Wishbone and scans it, one entry per clock, for each
 * frame header offered by the ingress parser.
 * Assumes the parser runs on clk_sys_i and holds its fields while
 * frm_valid_i is high and frm_ready_o is low.
 */
`timescale 1ns/100ps
`default_nettype none
`include "match_entry_defines.vh"

module frame_access_list_classifier #(
    parameter N_ENTRIES = 512,
    parameter IDX_W = 9,
    parameter N_PORTS = 26
) (
    input wire clk_sys_i,
    input wire reset_n_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output wire wb_ack_o,
    input wire frm_valid_i,
    output wire frm_ready_o,
    input wire [`PORT_W-1:0] frm_port_i,
    input wire [7:0] frm_policy_i,
    input wire [15:0] frm_etype_i,
    input wire [47:0] frm_source_hw_address_i,
    input wire [47:0] frm_dest_hw_address_i,
    input wire frm_tagged_i,
    input wire [11:0] frm_vid_i,
    input wire [2:0] frm_prio_i,
    input wire [13:0] frm_len_i,
    output reg res_valid_o,
    output reg res_hit_o,
    output reg [IDX_W-1:0] res_entry_o,
    output reg res_drop_o,
    output reg res_forward_o,
    output reg [`RATE_W-1:0] res_limiter_o,
    output reg res_redir_en_o,
    output reg [`PORT_W-1:0] res_redir_port_o,
    output reg res_log_o,
    output reg res_shut_o,
    output wire [N_PORTS-1:0] port_disabled_o
);

    // One-hot scan states
    localparam ST_IDLE = 2'b01;
    localparam ST_SCAN = 2'b10;

    reg rst_s1_q; // Reset synchroniser stages
    reg rst_n_q;
    reg [1:0] state_q; // Scan state
    reg [IDX_W-1:0] idx_q; // Entry under test
    reg [IDX_W-1:0] sel_q; // Entry picked for register access
    reg [IDX_W:0] lim_q; // Number of live entries
    reg ack_q; // Bus acknowledge
    reg last_hit_q; // Last frame result, for status
    reg [IDX_W-1:0] last_idx_q;
    reg [N_PORTS-1:0] shut_q; // Ports shut by entries
    // Latched frame header
    reg [`PORT_W-1:0] f_port_q;
    reg [7:0] f_pol_q;
    reg [15:0] f_etype_q;
    reg [47:0] f_source_hw_address_q;
    reg [47:0] f_dest_hw_address_q;
    reg f_tag_q;
    reg [11:0] f_vid_q;
    reg [2:0] f_prio_q;
    reg [13:0] f_len_q;
    // Entry storage, no reset: gated by lim_q
    reg [31:0] w0_mem [0:N_ENTRIES-1];
    reg [31:0] w1_mem [0:N_ENTRIES-1];
    reg [31:0] w2_mem [0:N_ENTRIES-1];
    reg [31:0] w3_mem [0:N_ENTRIES-1];
    reg [31:0] w4_mem [0:N_ENTRIES-1];
    reg [31:0] cnt_mem [0:N_ENTRIES-1];

    // Merge write data into a word under byte enables
    function [31:0] merge;
        input [31:0] old;
        input [31:0] dat;
        input [3:0] sel;
        integer b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (sel[b]) begin
                    merge[b*8 +: 8] = dat[b*8 +: 8];
                end
            end
        end
    endfunction

    // Reset release through two flops, assertion stays asynchronous
    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // Bus request decode
    wire req = wb_cyc_i & wb_stb_i & ~ack_q;
    wire wr = req & wb_we_i;
    wire [7:0] adr = {wb_adr_i[7:2], 2'b00};
    assign wb_ack_o = ack_q;

    // Current entry fields
    wire [31:0] e0 = w0_mem[idx_q];
    wire [31:0] e2 = w2_mem[idx_q];
    wire [31:0] e4 = w4_mem[idx_q];
    wire [47:0] e_source_hw_address = {e2[15:0], w1_mem[idx_q]};
    wire [47:0] e_dest_hw_address = {e2[`W2_DST_HI_LSB +: 16], w3_mem[idx_q]};
    wire [`TYPE_W-1:0] e_type = e0[`W0_TYPE_LSB +: `TYPE_W];
    wire [`DST_W-1:0] e_dm = e0[`W0_DST_LSB +: `DST_W];
    wire [7:0] e_pmask = e4[`W4_POL_MASK_LSB +: 8];

    // Frame class from the length/type field
    wire f_arp = (f_etype_q == `ETYPE_ARP) | (f_etype_q == `ETYPE_RARP);
    wire f_ip4 = (f_etype_q == `ETYPE_IP4);
    wire f_ip6 = (f_etype_q == `ETYPE_IP6);
    wire f_eth = (f_etype_q >= `ETYPE_MIN) & ~f_arp & ~f_ip4 & ~f_ip6;
    wire f_bcast = (f_dest_hw_address_q == `BCAST_ADDR);
    wire f_mcast = f_dest_hw_address_q[`GROUP_BIT] & ~f_bcast;
    wire f_short = (f_len_q < `MAX_REPORT_LEN);

    wire port_ok = ~e0[`W0_PORT_SPEC] | (e0[`W0_PORT_LSB +: `PORT_W] == f_port_q);
    wire pol_hit = ((f_pol_q ^ e4[`W4_POL_VAL_LSB +: 8]) & e_pmask) == 8'h00;
    wire pol_ok = ~e0[`W0_POL_SPEC] | pol_hit;
    // Source address only for these types
    wire src_use = e0[`W0_SRC_SPEC] & ((e_type == `FT_ETH) | (e_type == `FT_ARP));
    wire src_ok = ~src_use | (e_source_hw_address == f_source_hw_address_q);
    wire vid_ok = ~e0[`W0_VID_SPEC] | (f_tag_q & (e4[`W4_VID_LSB +: 12] == f_vid_q));
    wire prio_ok = ~e0[`W0_PRIO_SPEC] | (f_tag_q & (e4[`W4_PRIO_LSB +: 3] == f_prio_q));

    // Frame type and destination conditions
    reg type_ok;
    reg dst_ok;
    always @* begin
        case (e_type)
            `FT_ANY: type_ok = 1'b1;
            `FT_ETH: type_ok = f_eth;
            `FT_ARP: type_ok = f_arp;
            `FT_IP4: type_ok = f_ip4;
            `FT_IP6: type_ok = f_ip6;
            default: type_ok = 1'b0;
        endcase
        case (e_dm)
            `DM_ANY: dst_ok = 1'b1;
            `DM_MULTICAST_ONLY: dst_ok = f_mcast;
            `DM_BROADCAST_ONLY: dst_ok = f_bcast;
            `DM_UNICAST_ONLY: dst_ok = ~f_dest_hw_address_q[`GROUP_BIT];
            `DM_SPEC: dst_ok = (e_dest_hw_address == f_dest_hw_address_q);
            default: dst_ok = 1'b0;
        endcase
    end

    wire match = port_ok & pol_ok & type_ok & src_ok & dst_ok & vid_ok & prio_ok;
    wire last = ({1'b0, idx_q} + {{IDX_W{1'b0}}, 1'b1}) >= lim_q;
    wire scanning = state_q[1];
    wire hit_now = scanning & match;
    wire accept = frm_valid_i & frm_ready_o;
    wire permit = e0[`W0_PERMIT];
    assign frm_ready_o = state_q[0];
    assign port_disabled_o = shut_q;

    // Scan engine: one entry per clock, first hit ends the scan
    always @(posedge clk_sys_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= ST_IDLE;
            idx_q <= {IDX_W{1'b0}};
            res_valid_o <= 1'b0;
            res_hit_o <= 1'b0;
            res_entry_o <= {IDX_W{1'b0}};
            res_drop_o <= 1'b0;
            res_forward_o <= 1'b0;
            res_limiter_o <= {`RATE_W{1'b0}};
            res_redir_en_o <= 1'b0;
            res_redir_port_o <= {`PORT_W{1'b0}};
            res_log_o <= 1'b0;
            res_shut_o <= 1'b0;
            last_hit_q <= 1'b0;
            last_idx_q <= {IDX_W{1'b0}};
            f_port_q <= {`PORT_W{1'b0}};
            f_pol_q <= 8'h00;
            f_etype_q <= 16'h0000;
            f_source_hw_address_q <= 48'h000000000000;
            f_dest_hw_address_q <= 48'h000000000000;
            f_tag_q <= 1'b0;
            f_vid_q <= 12'h000;
            f_prio_q <= 3'h0;
            f_len_q <= 14'h0000;
        end else begin
            res_valid_o <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (accept) begin
                        f_port_q <= frm_port_i;
                        f_pol_q <= frm_policy_i;
                        f_etype_q <= frm_etype_i;
                        f_source_hw_address_q <= frm_source_hw_address_i;
                        f_dest_hw_address_q <= frm_dest_hw_address_i;
                        f_tag_q <= frm_tagged_i;
                        f_vid_q <= frm_vid_i;
                        f_prio_q <= frm_prio_i;
                        f_len_q <= frm_len_i;
                        idx_q <= {IDX_W{1'b0}};
                        if (lim_q == {(IDX_W+1){1'b0}}) begin
                            // Empty list: a miss, frame goes on
                            res_valid_o <= 1'b1;
                            res_hit_o <= 1'b0;
                            res_drop_o <= 1'b0;
                            res_forward_o <= 1'b1;
                            res_limiter_o <= {`RATE_W{1'b0}};
                            res_redir_en_o <= 1'b0;
                            res_log_o <= 1'b0;
                            res_shut_o <= 1'b0;
                            last_hit_q <= 1'b0;
                        end else begin
                            state_q <= ST_SCAN;
                        end
                    end
                end
                ST_SCAN: begin
                    // Stop at first hit in order
                    if (match | last) begin
                        state_q <= ST_IDLE;
                        res_valid_o <= 1'b1;
                        res_hit_o <= match;
                        res_entry_o <= idx_q;
                        last_hit_q <= match;
                        last_idx_q <= idx_q;
                        res_drop_o <= match & ~permit;
                        // Permit or miss keeps forwarding
                        res_forward_o <= ~match | permit;
                        res_limiter_o <= (match & permit) ? e0[`W0_RATE_LSB +: `RATE_W] : {`RATE_W{1'b0}};
                        res_redir_en_o <= match & permit & e0[`W0_REDIR_EN];
                        res_redir_port_o <= e0[`W0_REDIR_LSB +: `PORT_W];
                        res_log_o <= match & e0[`W0_LOG] & f_short;
                        res_shut_o <= match & e0[`W0_SHUT] & f_short;
                    end else begin
                        idx_q <= idx_q + {{(IDX_W-1){1'b0}}, 1'b1};
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Shut port mask: hardware set wins over software clear
    always @(posedge clk_sys_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            shut_q <= {N_PORTS{1'b0}};
        end else begin
            if (hit_now & e0[`W0_SHUT] & f_short) begin
                shut_q[f_port_q] <= 1'b1;
            end
            if (wr & (adr == `SHUT_OFS)) begin
                shut_q <= (shut_q & ~wb_dat_i[N_PORTS-1:0])
                    | ((hit_now & e0[`W0_SHUT] & f_short) ? ({{(N_PORTS-1){1'b0}}, 1'b1} << f_port_q)
                    : {N_PORTS{1'b0}});
            end
        end
    end

    // Hit counters; a hit in the clear cycle leaves a count of one
    always @(posedge clk_sys_i) begin
        if (wr & (adr == `CNT_OFS)) begin
            cnt_mem[sel_q] <= 32'h00000000;
        end
        if (hit_now) begin
            if (wr & (adr == `CNT_OFS) & (sel_q == idx_q)) begin
                cnt_mem[idx_q] <= 32'h00000001;
            end else begin
                cnt_mem[idx_q] <= cnt_mem[idx_q] + 32'h00000001;
            end
        end
    end

    // Entry words; writing during a scan may mix old and new fields
    always @(posedge clk_sys_i) begin
        if (wr & (adr == `W0_OFS)) begin
            w0_mem[sel_q] <= merge(w0_mem[sel_q], wb_dat_i, wb_sel_i);
        end
        if (wr & (adr == `W1_OFS)) begin
            w1_mem[sel_q] <= merge(w1_mem[sel_q], wb_dat_i, wb_sel_i);
        end
        if (wr & (adr == `W2_OFS)) begin
            w2_mem[sel_q] <= merge(w2_mem[sel_q], wb_dat_i, wb_sel_i);
        end
        if (wr & (adr == `W3_OFS)) begin
            w3_mem[sel_q] <= merge(w3_mem[sel_q], wb_dat_i, wb_sel_i);
        end
        if (wr & (adr == `W4_OFS)) begin
            w4_mem[sel_q] <= merge(w4_mem[sel_q], wb_dat_i, wb_sel_i);
        end
    end

    // Read mux, unmapped offsets read zero
    reg [31:0] rd;
    always @* begin
        rd = 32'h00000000;
        case (adr)
            `SEL_OFS: rd[IDX_W-1:0] = sel_q;
            `LIM_OFS: rd[IDX_W:0] = lim_q;
            `STAT_OFS: begin
                rd[`ST_BUSY] = scanning;
                rd[`ST_HIT] = last_hit_q;
                rd[`ST_IDX_LSB +: IDX_W] = last_idx_q;
            end
            `SHUT_OFS: rd[N_PORTS-1:0] = shut_q;
            `W0_OFS: rd = w0_mem[sel_q];
            `W1_OFS: rd = w1_mem[sel_q];
            `W2_OFS: rd = w2_mem[sel_q];
            `W3_OFS: rd = w3_mem[sel_q];
            `W4_OFS: rd = w4_mem[sel_q];
            `CNT_OFS: rd = cnt_mem[sel_q];
            default: rd = 32'h00000000;
        endcase
    end

    // Wishbone slave: one-cycle answer, control registers
    always @(posedge clk_sys_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ack_q <= 1'b0;
            wb_dat_o <= 32'h00000000;
            sel_q <= {IDX_W{1'b0}};
            lim_q <= {(IDX_W+1){1'b0}};
        end else begin
            ack_q <= req;
            if (req & ~wb_we_i) begin
                wb_dat_o <= rd;
            end
            if (wr & (adr == `SEL_OFS)) begin
                sel_q <= wb_dat_i[IDX_W-1:0];
            end
            if (wr & (adr == `LIM_OFS)) begin
                if (wb_dat_i[IDX_W:0] > N_ENTRIES[IDX_W:0]) begin
                    lim_q <= N_ENTRIES[IDX_W:0];
                end else begin
                    lim_q <= wb_dat_i[IDX_W:0];
                end
            end
        end
    end

endmodule
`default_nettype wire

// ===== frame_access_list_classifier_properties.sv
/*
 * Port checker for the frame classifier: bus answer, scan handshake
 * and consistency of each result pulse.
 * Assumes it is bound into frame_access_list_classifier.
 */
`timescale 1ns/100ps
`default_nettype none
`include "match_entry_defines.vh"
module frame_access_list_classifier_properties #(
    parameter IDX_W = 9,
    parameter N_PORTS = 26
) (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic frm_valid_i,
    input wire logic frm_ready_o,
    input wire logic res_valid_o,
    input wire logic res_hit_o,
    input wire logic res_drop_o,
    input wire logic res_forward_o,
    input wire logic [`RATE_W-1:0] res_limiter_o,
    input wire logic res_redir_en_o,
    input wire logic res_log_o,
    input wire logic res_shut_o,
    input wire logic [N_PORTS-1:0] port_disabled_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    // Bus request still waiting for its answer
    sequence s_bus_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    // Header handed to the scan
    sequence s_accept; frm_valid_i && frm_ready_o; endsequence
    // Result of a frame that hit nothing
    sequence s_miss; res_valid_o && !res_hit_o; endsequence
    chk_bus_answer: assert property (s_bus_req |=> wb_ack_o)
        else $error("bus request not answered in the next cycle");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus answer longer than one cycle");
    chk_ready_return: assert property ($rose(frm_ready_o) |-> res_valid_o)
        else $error("ready came back without a result");
    chk_result_bound: assert property (s_accept |-> ##[1:514] res_valid_o)
        else $error("no result within a full list scan");
    chk_drop_forward: assert property (res_valid_o |-> res_forward_o != res_drop_o && (!res_drop_o || res_hit_o))
        else $error("drop and forward disagree");
    chk_miss_quiet: assert property (s_miss |-> !res_drop_o && !res_log_o && !res_shut_o && !res_redir_en_o && res_limiter_o == 0)
        else $error("miss carries an action");
    chk_limiter_range: assert property (res_valid_o |-> res_limiter_o <= 16)
        else $error("limiter number out of range");
    chk_deny_plain: assert property (res_valid_o && res_drop_o |-> !res_redir_en_o && res_limiter_o == 0)
        else $error("dropped frame redirected or policed");
    chk_shut_mask: assert property ((port_disabled_o & ~$past(port_disabled_o)) != 0 |-> (res_valid_o && res_shut_o) || $past(res_valid_o && res_shut_o))
        else $error("port disabled without a shutdown hit");
endmodule
bind frame_access_list_classifier frame_access_list_classifier_properties #(.IDX_W(IDX_W), .N_PORTS(N_PORTS)) u_props (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .frm_valid_i(frm_valid_i), .frm_ready_o(frm_ready_o), .res_valid_o(res_valid_o), .res_hit_o(res_hit_o),
    .res_drop_o(res_drop_o), .res_forward_o(res_forward_o), .res_limiter_o(res_limiter_o),
    .res_redir_en_o(res_redir_en_o), .res_log_o(res_log_o), .res_shut_o(res_shut_o), .port_disabled_o(port_disabled_o));
`default_nettype wire

// ===== ingress_parser_model.sv
/*
 * Ingress parser model: offers one header at a time, promptly or late.
 * Assumes send is called just after a rising clock edge.
 */
`timescale 1ns/100ps
`default_nettype none
module ingress_parser_model (
    input wire logic clk_sys_i,
    input wire logic frm_ready_i,
    output logic frm_valid_o,
    output logic [154:0] frm_hdr_o
);
    // Idle at time zero
    initial begin
        frm_valid_o = 1'b0;
        frm_hdr_o = 155'h0;
    end
    // Hold the header until taken; idle fields inverted so stale data never matches
    task automatic send(input logic [154:0] hdr, input int gap);
        repeat (gap) @(posedge clk_sys_i);
        frm_valid_o <= 1'b1;
        frm_hdr_o <= hdr;
        do @(posedge clk_sys_i); while (frm_ready_i !== 1'b1);
        frm_valid_o <= 1'b0;
        frm_hdr_o <= ~hdr;
    endtask
endmodule
`default_nettype wire

// ===== frame_access_list_classifier_bench.sv
/*
 * Bench for the frame classifier: random entries and headers checked
 * against a reference of the match rules. Assumes one 125 MHz clock.
 */
`timescale 1ns/100ps
`default_nettype none
`include "match_entry_defines.vh"
`define CMP(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin error_cnt++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module frame_access_list_classifier_bench;
    logic clk_sys_i = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, dat_o, w0, e_w0 [8], e_w4 [8];
    logic [47:0] e_sm [8], e_dm [8];
    logic [154:0] hdr, hv;
    logic valid, ready, ack, rv, hit, drop, fwd, ren, lg, sh;
    logic [8:0] ent;
    logic [4:0] lmt, rport;
    logic [25:0] pdis, mask_exp = 26'h0;
    int error_cnt = 0, check_count = 0, cycles = 0, cnt_exp [8], last_k;
    logic [7:0] offs [4] = '{`STAT_OFS, `LIM_OFS, `SHUT_OFS, 8'h3c};
    logic [15:0] et_tab [7] = '{16'h0806, 16'h8035, 16'h0800, 16'h86dd, 16'h0600, 16'h05ff, 16'h9000};
    logic [47:0] mac_tab [4] = '{48'hffffffffffff, 48'h01005e000001, 48'h00000000a001, 48'h00000000a002};
    logic [13:0] len_tab [4] = '{14'h040, 14'h5ed, 14'h5ee, 14'h5dc};

    frame_access_list_classifier u_frame_access_list_classifier (
        .clk_sys_i(clk_sys_i), .reset_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .frm_valid_i(valid), .frm_ready_o(ready), .frm_port_i(hdr[154:150]), .frm_policy_i(hdr[149:142]),
        .frm_etype_i(hdr[141:126]), .frm_source_hw_address_i(hdr[125:78]),
        .frm_dest_hw_address_i(hdr[77:30]), .frm_tagged_i(hdr[29]),
        .frm_vid_i(hdr[28:17]), .frm_prio_i(hdr[16:14]), .frm_len_i(hdr[13:0]), .res_valid_o(rv),
        .res_hit_o(hit), .res_entry_o(ent), .res_drop_o(drop), .res_forward_o(fwd), .res_limiter_o(lmt),
        .res_redir_en_o(ren), .res_redir_port_o(rport), .res_log_o(lg), .res_shut_o(sh), .port_disabled_o(pdis));
    ingress_parser_model u_ingress_parser_model (.clk_sys_i(clk_sys_i), .frm_ready_i(ready),
        .frm_valid_o(valid), .frm_hdr_o(hdr));

    // Free-running clock and a cycle ceiling against hangs
    always #4 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            conclude();
        end
    end

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Classic single bus cycle; held until ack, data taken at that edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_sys_i); while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_sys_i);
    endtask

    // Reference of one entry against one header
    function automatic bit ref_hit(int i, logic [154:0] h);
        logic [31:0] w;
        logic [15:0] et;
        logic [47:0] dm;
        logic [2:0] cls;
        bit ok;
        w = e_w0[i];
        et = h[141:126];
        dm = h[77:30];
        cls = (et == `ETYPE_ARP || et == `ETYPE_RARP) ? `FT_ARP : (et == `ETYPE_IP4) ? `FT_IP4 :
              (et == `ETYPE_IP6) ? `FT_IP6 : (et >= `ETYPE_MIN) ? `FT_ETH : 3'h7;
        ok = (w[9:7] == `FT_ANY || w[9:7] == cls);
        ok = ok && (!w[0] || w[5:1] == h[154:150]);
        ok = ok && (!w[6] || ((h[149:142] ^ e_w4[i][7:0]) & e_w4[i][15:8]) == 8'h00);
        ok = ok && (!w[24] || !(w[9:7] == `FT_ETH || w[9:7] == `FT_ARP) || h[125:78] == e_sm[i]);
        case (w[27:25])
            `DM_MULTICAST_ONLY: ok = ok && dm[`GROUP_BIT] && dm != `BCAST_ADDR;
            `DM_BROADCAST_ONLY: ok = ok && dm == `BCAST_ADDR;
            `DM_UNICAST_ONLY: ok = ok && !dm[`GROUP_BIT];
            `DM_SPEC: ok = ok && dm == e_dm[i];
            default: ;
        endcase
        ok = ok && (!w[28] || (h[29] && h[28:17] == e_w4[i][27:16]));
        ok = ok && (!w[29] || (h[29] && h[16:14] == e_w4[i][30:28]));
        return ok;
    endfunction

    function automatic logic [154:0] rnd_hdr();
        return {5'($urandom % 4), 8'($urandom), et_tab[$urandom % 7], mac_tab[2 + $urandom % 2],
            mac_tab[$urandom % 4], 1'($urandom), 12'(1 + $urandom % 2), 3'($urandom % 2), len_tab[$urandom % 4]};
    endfunction

    // Write one entry at index i and clear its counter
    task automatic put_entry(int i, logic [31:0] w, logic [31:0] w4, logic [47:0] sm, logic [47:0] dm);
        e_w0[i] = w;
        e_w4[i] = w4;
        e_sm[i] = sm;
        e_dm[i] = dm;
        cnt_exp[i] = 0;
        wb(1'b1, `SEL_OFS, 32'(i));
        wb(1'b1, `W0_OFS, w);
        wb(1'b1, `W1_OFS, sm[31:0]);
        wb(1'b1, `W2_OFS, {dm[47:32], sm[47:32]});
        wb(1'b1, `W3_OFS, dm[31:0]);
        wb(1'b1, `W4_OFS, w4);
        wb(1'b1, `CNT_OFS, 32'h0);
    endtask

    // Offer one header and compare its result with the first reference hit
    task automatic run_frame(logic [154:0] h, int lim);
        int k;
        int n;
        logic [31:0] w;
        logic on;
        k = -1;
        n = 0;
        for (int i = lim - 1; i >= 0; i--) begin
            if (ref_hit(i, h))
                k = i;
        end
        w = (k >= 0) ? e_w0[k] : 32'h0;
        on = (k >= 0) && (h[13:0] < `MAX_REPORT_LEN);
        u_ingress_parser_model.send(h, $urandom % 3);
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (rv !== 1'b1);
        `CMP("latency", (k >= 0) ? k + 2 : lim + 1, n)
        `CMP("hit", k >= 0, hit)
        `CMP("drop", (k >= 0) && !w[10], drop)
        `CMP("forward", !((k >= 0) && !w[10]), fwd)
        `CMP("limiter", w[10] ? w[15:11] : 5'h00, lmt)
        `CMP("redirect", w[10] && w[16], ren)
        `CMP("log", on && w[22], lg)
        `CMP("shutdown", on && w[23], sh)
        if (k >= 0)
            `CMP("entry", 9'(k), ent)
        if (w[10] && w[16])
            `CMP("redirect port", w[21:17], rport)
        if (k >= 0)
            cnt_exp[k]++;
        if (on && w[23])
            mask_exp[h[154:150]] = 1'b1;
        last_k = k;
    endtask

    initial begin
        void'($urandom(14));
        repeat (4) @(posedge clk_sys_i);
        `CMP("ready in reset", 1'b1, ready)
        `CMP("mask in reset", 26'h0, pdis)
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        // Reset values; unmapped offset ignores writes
        wb(1'b1, 8'h3c, 32'hffffffff);
        foreach (offs[j]) begin
            wb(1'b0, offs[j], 32'h0);
            `CMP("reset read", 32'h0, rdat)
        end
        // Empty list: miss and forward
        run_frame(rnd_hdr(), 0);
        // Class boundaries against one Ethernet-type permit entry with log and shutdown
        put_entry(0, 32'h00c00480, 32'h0, 48'h0, 48'h0);
        wb(1'b1, `LIM_OFS, 32'h1);
        foreach (et_tab[j]) begin
            hv = rnd_hdr();
            hv[141:126] = et_tab[j];
            run_frame(hv, 1);
        end
        // Random list of eight entries, sparse conditions
        for (int i = 0; i < 8; i++) begin
            w0 = $urandom & $urandom & 32'h3fffffff;
            w0[10] = 1'($urandom);
            w0[9:7] = 3'($urandom % 6);
            w0[15:11] = 5'($urandom % 17);
            w0[21:17] = 5'($urandom % 26);
            w0[27:25] = 3'($urandom % 5);
            w0[5:1] = 5'($urandom % 4);
            put_entry(i, w0, {1'b0, 3'($urandom % 2), 12'(1 + $urandom % 2), 16'($urandom)},
                mac_tab[2 + $urandom % 2], mac_tab[$urandom % 4]);
        end
        wb(1'b1, `LIM_OFS, 32'h8);
        repeat (80) run_frame(rnd_hdr(), 8);
        // Counters, status and port mask
        for (int i = 0; i < 8; i++) begin
            wb(1'b1, `SEL_OFS, 32'(i));
            wb(1'b0, `CNT_OFS, 32'h0);
            `CMP("hit counter", cnt_exp[i], rdat)
        end
        wb(1'b0, `STAT_OFS, 32'h0);
        `CMP("status hit", last_k >= 0, rdat[`ST_HIT])
        `CMP("port mask", mask_exp, pdis)
        wb(1'b0, `SHUT_OFS, 32'h0);
        `CMP("mask read", 32'(mask_exp), rdat)
        wb(1'b1, `SHUT_OFS, 32'h03ffffff);
        `CMP("mask cleared", 26'h0, pdis)
        conclude();
    end
endmodule
`default_nettype wire
